// file: sstdc_top.sv
// What this block does
// - Field camera steps overlapping raster, counting photons.
// - Each raster count goes out with coordinates.
// - Tracking enabled: bright star stops raster, tracks.
// - Track pattern then centres on that star.
// - Primary mode tracks commanded point, reports offset.
// - Slow scan dwells four times longer.
// - Count up first point, down second point.
// - Error steers pattern and reports off-null.
// - Saturated counters make error data invalid.
// - Dwell spacing selects overlap or underlap.
// - Lost star presence holds pattern in place.
// - Continue pulse drops track outside primary mode, clears offsets.
// - Search steps once every 2.4 ms in search-track mode, once per dwell in field camera.
// - Count above chosen threshold starts tracking.
// - Nominal dwell per position is 25.6 ms.
// - Photon counter holds at 28672.
// - System mode changes only on command.
`timescale 1ns/1ps
`default_nettype none
module sstdc_top import sstdc_pkg::*; #(
	parameter int DWELL_CYCLES = DWELL_CYCLES_NOM,
	parameter int SEARCH_CYCLES = SEARCH_CYCLES_NOM
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic srst,
	// Register port.
	input wire logic [7:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_we,
	input wire logic bus_re,
	output logic [31:0] bus_rdata,
	// Pins from the detector and the command link.
	input wire logic photon_pulse,
	input wire logic continue_search_pulse,
	// Aperture deflection.
	output logic [COORD_W-1:0] aperture_x,
	output logic [COORD_W-1:0] aperture_y,
	// Raster telemetry.
	output logic tlm_valid,
	output logic [CNT_W-1:0] tlm_count,
	output logic [COORD_W-1:0] tlm_x,
	output logic [COORD_W-1:0] tlm_y,
	// Track error.
	output logic err_valid,
	output logic [COORD_W-1:0] err_x,
	output logic [COORD_W-1:0] err_y,
	output logic [15:0] err_diff,
	output logic err_invalid,
	output logic tracking
);
	function automatic logic hits(input logic [7:0] a, input logic [7:0] r);
		return a == r;
	endfunction

	logic [2:0] ph_sync, cs_sync;
	logic [1:0] mode;
	logic track_en, slow, underlap;
	logic [1:0] thr_sel;
	logic [COORD_W-1:0] cmd_x, cmd_y, raster_x, raster_y, off_x, off_y;
	logic [CNT_W-1:0] thr [4];
	sstdc_state_t state, next_state;
	logic axis_y, presence, restart_q;
	logic [31:0] rd_mux;

	// The second stage alone feeds logic; the third only marks edges.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ph_sync <= '0;
			cs_sync <= '0;
		end else begin
			ph_sync <= {ph_sync[1:0], photon_pulse};
			cs_sync <= {cs_sync[1:0], continue_search_pulse};
		end
	end
	wire photon_inc = ph_sync[1] && !ph_sync[2];
	wire csc_rise = cs_sync[1] && !cs_sync[2];

	wire ctrl_wr = bus_we && hits(bus_addr, REG_CTRL);
	wire coord_wr = bus_we && hits(bus_addr, REG_COORD);
	wire thr_wr = bus_we && hits(bus_addr & REG_THR_MASK, REG_THR);
	wire [1:0] thr_idx = bus_addr[THR_IDX_LSB +: 2];

	// Modes move only on a control write; submodes follow events.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			mode <= MODE_FIELD_CAMERA;
			{track_en, slow, underlap} <= '0;
			thr_sel <= '0;
		end else if (ctrl_wr) begin
			mode <= bus_wdata[CTRL_MODE_LSB +: 2];
			track_en <= bus_wdata[CTRL_TRACK_EN];
			slow <= bus_wdata[CTRL_SLOW];
			underlap <= bus_wdata[CTRL_UNDERLAP];
			thr_sel <= bus_wdata[CTRL_THR_LSB +: 2];
		end
	end

	// New coordinates reach the raster at the next control write or continue pulse; the track centre uses them at once.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cmd_x <= '0;
			cmd_y <= '0;
		end else if (coord_wr) begin
			cmd_x <= bus_wdata[0 +: COORD_W];
			cmd_y <= bus_wdata[COORD_Y_LSB +: COORD_W];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			thr <= '{default: THR_RESET};
		end else if (thr_wr) begin
			thr[thr_idx] <= bus_wdata[CNT_W-1:0];
		end
	end

	// A command or a continue pulse restarts the pattern one cycle later,
	// once the new mode and coordinates are settled in their registers.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			restart_q <= 1'b0;
		end else begin
			restart_q <= ctrl_wr || csc_rise;
		end
	end

	logic tmr_done, up_sat, dn_sat;
	logic [CNT_W-1:0] up_count, dn_count;
	logic [TMR_W-1:0] period;

	wire is_search = (state == ST_SEARCH);
	wire is_b = (state == ST_TRACK_B);
	wire track_allowed = (mode == MODE_SEARCH_TRACK) ||
		((mode == MODE_FIELD_CAMERA) && track_en);
	wire [CNT_W-1:0] thr_cur = thr[thr_sel];
	wire star_hit = track_allowed && (up_count > thr_cur);
	wire [15:0] sum = {1'b0, up_count} + {1'b0, dn_count};
	wire [15:0] diff = {1'b0, up_count} - {1'b0, dn_count};
	wire bad = up_sat || dn_sat;
	wire star_seen = sum > {1'b0, thr_cur};
	wire [15:0] diff_sh = $signed(diff) >>> ERR_SHIFT;
	wire [COORD_W-1:0] steer = diff_sh[COORD_W-1:0];
	wire [COORD_W-1:0] half = underlap ? UNDERLAP_HALF : OVERLAP_HALF;
	wire steer_ok = tmr_done && is_b && !bad && star_seen;
	wire [COORD_W-1:0] ctr_x = cmd_x + off_x;
	wire [COORD_W-1:0] ctr_y = cmd_y + off_y;
	wire row_end = (raster_x == ~RASTER_STEP + 8'h01);

	always_comb begin
		next_state = state;
		if (restart_q) begin
			next_state = (mode == MODE_PRIMARY) ? ST_TRACK_A : ST_SEARCH;
		end else if (tmr_done) begin
			case (state)
				ST_SEARCH: next_state = star_hit ? ST_TRACK_A : ST_SEARCH;
				ST_TRACK_A: next_state = ST_TRACK_B;
				ST_TRACK_B: next_state = ST_TRACK_A;
				default: next_state = ST_SEARCH;
			endcase
		end
	end

	// One base dwell scaled by one or four; search in search-track mode has its own step.
	wire [TMR_W-1:0] dwell = TMR_W'(DWELL_CYCLES);
	wire [TMR_W-1:0] slow_dwell = TMR_W'(DWELL_CYCLES * SLOW_FACTOR);
	wire [TMR_W-1:0] track_period = slow ? slow_dwell : dwell;
	wire [TMR_W-1:0] search_period = (mode == MODE_SEARCH_TRACK) ?
		TMR_W'(SEARCH_CYCLES) : dwell;
	assign period = (next_state == ST_SEARCH) ? search_period : track_period;

	sstdc_dwell_timer u_timer (
		.ref_clk(ref_clk),
		.srst(srst),
		.start(restart_q),
		.period(period),
		.done(tmr_done)
	);

	// Up counts in search and at the first dwell, down at the second.
	sstdc_photon_counter u_up (
		.ref_clk(ref_clk),
		.srst(srst),
		.clr(restart_q || (tmr_done && state != ST_TRACK_A)),
		.en(!is_b),
		.inc(photon_inc),
		.count(up_count),
		.sat(up_sat)
	);

	sstdc_photon_counter u_dn (
		.ref_clk(ref_clk),
		.srst(srst),
		.clr(restart_q || (tmr_done && state == ST_TRACK_A)),
		.en(is_b),
		.inc(photon_inc),
		.count(dn_count),
		.sat(dn_sat)
	);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state <= ST_SEARCH;
			axis_y <= 1'b0;
		end else begin
			state <= next_state;
			if (restart_q) begin
				axis_y <= 1'b0;
			end else if (tmr_done && is_b) begin
				axis_y <= !axis_y;
			end
		end
	end

	// The raster steps from the commanded corner; rows advance only when x steps off the row end.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			raster_x <= '0;
			raster_y <= '0;
		end else if (restart_q) begin
			raster_x <= cmd_x;
			raster_y <= cmd_y;
		end else if (tmr_done && is_search && !star_hit) begin
			raster_x <= raster_x + RASTER_STEP;
			if (row_end) begin
				raster_y <= raster_y + RASTER_STEP;
			end
		end
	end

	// Offsets steer the centre; a second dwell above the first means the
	// star lies on the plus side, so the centre moves up the axis.
	always_ff @(posedge ref_clk) begin
		if (srst || csc_rise) begin
			off_x <= '0;
			off_y <= '0;
		end else if (tmr_done && is_search && star_hit) begin
			off_x <= raster_x - cmd_x;
			off_y <= raster_y - cmd_y;
		end else if (steer_ok && !axis_y) begin
			off_x <= off_x - steer;
		end else if (steer_ok && axis_y) begin
			off_y <= off_y - steer;
		end
	end

	wire [COORD_W-1:0] dx = (axis_y || is_search) ? '0 : half;
	wire [COORD_W-1:0] dy = (axis_y && !is_search) ? half : '0;
	wire [COORD_W-1:0] next_ap_x = is_search ? raster_x :
		(is_b ? ctr_x + dx : ctr_x - dx);
	wire [COORD_W-1:0] next_ap_y = is_search ? raster_y :
		(is_b ? ctr_y + dy : ctr_y - dy);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			aperture_x <= '0;
			aperture_y <= '0;
		end else begin
			aperture_x <= next_ap_x;
			aperture_y <= next_ap_y;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			tlm_valid <= 1'b0;
			tlm_count <= '0;
			tlm_x <= '0;
			tlm_y <= '0;
		end else begin
			tlm_valid <= tmr_done && is_search && !restart_q;
			if (tmr_done && is_search) begin
				tlm_count <= up_count;
				tlm_x <= raster_x;
				tlm_y <= raster_y;
			end
		end
	end

	// Loss of presence keeps the last centre; the status presence bit stays clear meanwhile.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			err_valid <= 1'b0;
			err_invalid <= 1'b0;
			err_diff <= '0;
			presence <= 1'b0;
		end else begin
			err_valid <= tmr_done && is_b && !restart_q;
			if (tmr_done && is_b) begin
				err_invalid <= bad;
				err_diff <= diff;
				presence <= star_seen;
			end
		end
	end
	assign err_x = off_x;
	assign err_y = off_y;
	assign tracking = !is_search;

	always_comb begin
		rd_mux = '0;
		if (hits(bus_addr, REG_CTRL)) begin
			rd_mux[6:0] = {thr_sel, underlap, slow, track_en, mode};
		end else if (hits(bus_addr, REG_COORD)) begin
			rd_mux[15:0] = {cmd_y, cmd_x};
		end else if (hits(bus_addr, REG_STATUS)) begin
			rd_mux[5:0] = {err_invalid, presence, axis_y, state};
		end else if (hits(bus_addr, REG_POS)) begin
			rd_mux[15:0] = {aperture_y, aperture_x};
		end else if (hits(bus_addr & REG_THR_MASK, REG_THR)) begin
			rd_mux[CNT_W-1:0] = thr[thr_idx];
		end else if (hits(bus_addr, REG_ERR)) begin
			rd_mux[15:0] = {off_y, off_x};
		end else if (hits(bus_addr, REG_DIFF)) begin
			rd_mux[15:0] = err_diff;
		end else if (hits(bus_addr, REG_COUNT)) begin
			rd_mux[CNT_W-1:0] = tlm_count;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			bus_rdata <= '0;
		end else begin
			bus_rdata <= bus_re ? rd_mux : '0;
		end
	end

	mode_by_command_a: assert property (@(posedge ref_clk) disable iff (srst)
		!ctrl_wr |=> $stable(mode))
		else $error("mode changed without a control write");
	tlm_position_a: assert property (@(posedge ref_clk) disable iff (srst)
		tlm_valid |-> tlm_x == $past(raster_x) && tlm_y == $past(raster_y))
		else $error("telemetry coordinates do not match the raster step");
	csc_clears_a: assert property (@(posedge ref_clk) disable iff (srst)
		csc_rise |=> off_x == '0 && off_y == '0 ##1 state == ST_TRACK_A ||
		state == ST_SEARCH)
		else $error("continue pulse did not clear the offsets");
	search_to_track_a: assert property (@(posedge ref_clk) disable iff (srst)
		tmr_done && is_search && star_hit && !restart_q |=> state == ST_TRACK_A)
		else $error("threshold crossing did not start tracking");
	invalid_flag_a: assert property (@(posedge ref_clk) disable iff (srst)
		err_valid |-> err_invalid == $past(up_sat || dn_sat))
		else $error("saturated dwell not flagged invalid");
	hold_on_loss_a: assert property (@(posedge ref_clk) disable iff (srst)
		tmr_done && is_b && !star_seen && !csc_rise |=>
		$stable(off_x) && $stable(off_y))
		else $error("pattern moved after star presence was lost");
	slow_dwell_a: assert property (@(posedge ref_clk) disable iff (srst)
		next_state != ST_SEARCH && slow |->
		period == TMR_W'(DWELL_CYCLES * SLOW_FACTOR))
		else $error("slow scan dwell is not four base dwells");
	search_step_a: assert property (@(posedge ref_clk) disable iff (srst)
		next_state == ST_SEARCH && mode == MODE_SEARCH_TRACK |->
		period == TMR_W'(SEARCH_CYCLES))
		else $error("search step period wrong");

	acquire_c: cover property (@(posedge ref_clk) disable iff (srst)
		is_search ##1 state == ST_TRACK_A);
	error_out_c: cover property (@(posedge ref_clk) disable iff (srst)
		err_valid && !err_invalid);
	saturate_c: cover property (@(posedge ref_clk) disable iff (srst)
		err_valid && err_invalid);
endmodule
`default_nettype wire

// file: sstdc_pkg.sv
package sstdc_pkg;
	// Timing, given in its own unit and converted at the 50 MHz reference.
	localparam int CLK_PERIOD_NS = 20;
	localparam int DWELL_NS = 25_600_000;
	localparam int SEARCH_STEP_NS = 2_400_000;
	localparam int DWELL_CYCLES_NOM = DWELL_NS / CLK_PERIOD_NS;
	localparam int SEARCH_CYCLES_NOM = SEARCH_STEP_NS / CLK_PERIOD_NS;
	localparam int SLOW_FACTOR = 4;
	localparam int TMR_W = 24;

	// Photon counting.
	localparam int CNT_W = 15;
	localparam logic [CNT_W-1:0] SAT_LIMIT = 15'h7000;
	localparam logic [CNT_W-1:0] THR_RESET = 15'h0100;

	// Aperture geometry in coarse coordinate units.
	localparam int COORD_W = 8;
	localparam logic [COORD_W-1:0] RASTER_STEP = 8'h04;
	localparam logic [COORD_W-1:0] OVERLAP_HALF = 8'h01;
	localparam logic [COORD_W-1:0] UNDERLAP_HALF = 8'h04;
	localparam int ERR_SHIFT = 4;

	// Register byte offsets.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_COORD = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_POS = 8'h0c;
	localparam logic [7:0] REG_THR = 8'h10;
	localparam logic [7:0] REG_THR_MASK = 8'hf3;
	localparam logic [7:0] REG_ERR = 8'h20;
	localparam logic [7:0] REG_DIFF = 8'h24;
	localparam logic [7:0] REG_COUNT = 8'h28;

	// Control and coordinate register fields; threshold index address bit.
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_TRACK_EN = 2;
	localparam int CTRL_SLOW = 3;
	localparam int CTRL_UNDERLAP = 4;
	localparam int CTRL_THR_LSB = 5;
	localparam int COORD_Y_LSB = 8;
	localparam int THR_IDX_LSB = 2;

	typedef enum logic [1:0] {
		MODE_PRIMARY = 2'h0,
		MODE_SEARCH_TRACK = 2'h1,
		MODE_FIELD_CAMERA = 2'h2
	} sstdc_mode_t;

	typedef enum logic [2:0] {
		ST_SEARCH = 3'h1,
		ST_TRACK_A = 3'h2,
		ST_TRACK_B = 3'h4
	} sstdc_state_t;
endpackage

// file: sstdc_dwell_timer.sv
`timescale 1ns/1ps
`default_nettype none
module sstdc_dwell_timer import sstdc_pkg::*; (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic srst,
	// Control.
	input wire logic start,
	input wire logic [TMR_W-1:0] period,
	// Period elapsed.
	output logic done
);
	logic [TMR_W-1:0] cnt;
	logic running;

	assign done = running && (cnt == '0);

	// The period is sampled at every reload, so a caller can change the
	// dwell length for the next position in the very cycle of done.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cnt <= '0;
			running <= 1'b0;
		end else if (start || done) begin
			cnt <= period - TMR_W'(1);
			running <= 1'b1;
		end else if (running) begin
			cnt <= cnt - TMR_W'(1);
		end
	end
endmodule
`default_nettype wire

// file: sstdc_photon_counter.sv
`timescale 1ns/1ps
`default_nettype none
module sstdc_photon_counter import sstdc_pkg::*; (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic srst,
	// Control.
	input wire logic clr,
	input wire logic en,
	input wire logic inc,
	// Result.
	output logic [CNT_W-1:0] count,
	output logic sat
);
	assign sat = (count == SAT_LIMIT);

	always_ff @(posedge ref_clk) begin
		if (srst || clr) begin
			count <= '0;
		end else if (en && inc && !sat) begin
			count <= count + CNT_W'(1);
		end
	end

	sat_holds_a: assert property (@(posedge ref_clk) disable iff (srst)
		sat && !clr |=> sat && count == SAT_LIMIT)
		else $error("photon counter left its limit without a clear");
endmodule
`default_nettype wire

// file: sstdc_link_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stands in for the detector and the command link at the block's pins.
module sstdc_link_model #(
	parameter int PULSE_CYCLES = 30
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic srst,
	// Requests from the bench.
	input wire logic [7:0] photon_period,
	input wire logic csp_go,
	// Pins toward the block.
	output logic photon_pulse,
	output logic continue_search_pulse
);
	logic [7:0] ph_cnt;
	logic [15:0] csp_cnt;

	// A period of zero stops all photon events.
	always_ff @(posedge ref_clk) begin
		if (srst || photon_period == 8'h00) begin
			ph_cnt <= 8'h00;
			photon_pulse <= 1'b0;
		end else begin
			photon_pulse <= (ph_cnt == 8'h00);
			ph_cnt <= (ph_cnt == photon_period - 8'h01) ? 8'h00 : ph_cnt + 8'h01;
		end
	end

	// The pulse is positive and of fixed width, scaled down from 15 ms.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			csp_cnt <= 16'h0000;
			continue_search_pulse <= 1'b0;
		end else if (csp_go && csp_cnt == 16'h0000) begin
			csp_cnt <= 16'(PULSE_CYCLES);
			continue_search_pulse <= 1'b1;
		end else begin
			if (csp_cnt != 16'h0000)
				csp_cnt <= csp_cnt - 16'h0001;
			continue_search_pulse <= (csp_cnt > 16'h0001);
		end
	end
endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench import sstdc_pkg::*;;
	localparam int DW = 40;
	localparam int SC = 10;
	logic ref_clk, srst, bus_we, bus_re, csp_go;
	logic [7:0] bus_addr, phot, x0, y0, half;
	logic [31:0] bus_wdata, bus_rdata, d, seed;
	logic photon_pulse, continue_search_pulse, tlm_valid, err_valid;
	logic err_invalid, tracking;
	logic [COORD_W-1:0] aperture_x, aperture_y, tlm_x, tlm_y, err_x, err_y;
	logic [CNT_W-1:0] tlm_count;
	logic [15:0] err_diff;
	int n_mismatch, tests_run, i, j, n;

	sstdc_top #(.DWELL_CYCLES(DW), .SEARCH_CYCLES(SC)) i_dut (
		.ref_clk(ref_clk), .srst(srst), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_we(bus_we), .bus_re(bus_re),
		.bus_rdata(bus_rdata), .photon_pulse(photon_pulse),
		.continue_search_pulse(continue_search_pulse),
		.aperture_x(aperture_x), .aperture_y(aperture_y),
		.tlm_valid(tlm_valid), .tlm_count(tlm_count), .tlm_x(tlm_x),
		.tlm_y(tlm_y), .err_valid(err_valid), .err_x(err_x), .err_y(err_y),
		.err_diff(err_diff), .err_invalid(err_invalid), .tracking(tracking)
	);

	sstdc_link_model #(.PULSE_CYCLES(30)) i_link (
		.ref_clk(ref_clk), .srst(srst), .photon_period(phot),
		.csp_go(csp_go), .photon_pulse(photon_pulse),
		.continue_search_pulse(continue_search_pulse)
	);

	always #10 ref_clk = ~ref_clk;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		bus_we <= 1'b1;
		bus_addr <= a;
		bus_wdata <= v;
		@(posedge ref_clk);
		bus_we <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge ref_clk);
		bus_re <= 1'b1;
		bus_addr <= a;
		@(posedge ref_clk);
		bus_re <= 1'b0;
		#1 v = bus_rdata;
	endtask

	// Kinds: 0 raster sample, 1 error sample, 2 track on, 3 track off.
	task automatic wait_ev(input int kind, output int cyc);
		logic hit;
		cyc = 0;
		hit = 1'b0;
		while (!hit) begin
			@(posedge ref_clk);
			#1 cyc++;
			case (kind)
				0: hit = (tlm_valid === 1'b1);
				1: hit = (err_valid === 1'b1);
				2: hit = (tracking === 1'b1);
				default: hit = (tracking === 1'b0);
			endcase
			if (cyc > 2000) begin
				n_mismatch++;
				$display("[FAIL] %0t wait %0d ran out", $time, kind);
				report_and_stop();
			end
		end
	endtask

	initial begin
		ref_clk = 1'b0;
		srst = 1'b1;
		bus_we = 1'b0;
		bus_re = 1'b0;
		bus_addr = 8'h00;
		bus_wdata = 32'h0;
		csp_go = 1'b0;
		phot = 8'h00;
		seed = 32'h9ef14111;
		repeat (8) @(posedge ref_clk);
		srst <= 1'b0;
		for (i = 0; i < 4; i++) begin
			rd(8'(REG_THR + 8'(4 * i)), d);
			chk(d, {17'h0, THR_RESET});
		end
		rd(8'h3c, d);
		chk(d, 32'h0);
		seed = lfsr(seed);
		wr(REG_THR, {17'h0, seed[14:0]});
		rd(REG_THR, d);
		chk(d, {17'h0, seed[14:0]});
		// Field camera, tracking off: raster from the commanded point.
		seed = lfsr(seed);
		x0 = seed[7:0];
		y0 = seed[15:8];
		phot <= 8'h05;
		wr(REG_COORD, {16'h0, y0, x0});
		wr(REG_CTRL, 32'h2);
		wait_ev(0, n);
		chk({24'h0, tlm_x}, {24'h0, x0});
		chk({24'h0, tlm_y}, {24'h0, y0});
		wait_ev(0, n);
		chk(n, DW);
		chk(32'(tlm_count >= 15'd7 && tlm_count <= 15'd9), 1);
		chk(32'(tlm_x != x0 || tlm_y != y0), 1);
		// Each threshold select in turn; the last pass is field camera.
		for (i = 0; i < 4; i++) begin
			phot <= 8'h00;
			for (j = 0; j < 4; j++)
				wr(8'(REG_THR + 8'(4 * j)), (i == j) ? 32'h1 : 32'h7fff);
			wr(REG_CTRL, (i << 5) | ((i == 3) ? 32'h6 : 32'h1));
			wait_ev(0, n);
			wait_ev(0, n);
			if (i < 3)
				chk(n, SC);
			chk({31'h0, tracking}, 0);
			phot <= 8'h04;
			wait_ev(2, n);
			chk({31'h0, tracking}, 1);
		end
		// Break track toward new coordinates loaded beforehand.
		phot <= 8'h00;
		seed = lfsr(seed);
		x0 = seed[7:0];
		y0 = seed[15:8];
		wr(REG_COORD, {16'h0, y0, x0});
		@(posedge ref_clk);
		csp_go <= 1'b1;
		@(posedge ref_clk);
		csp_go <= 1'b0;
		wait_ev(3, n);
		chk({31'h0, tracking}, 0);
		rd(REG_ERR, d);
		chk(d, 32'h0);
		chk({16'h0, err_y, err_x}, 32'h0);
		wait_ev(0, n);
		chk({16'h0, tlm_y, tlm_x}, {16'h0, y0, x0});
		// Primary mode, overlap then underlap spacing.
		wr(REG_THR, 32'h1);
		for (i = 0; i < 2; i++) begin
			phot <= 8'h04;
			wr(REG_CTRL, (i == 1) ? 32'h10 : 32'h0);
			half = (i == 1) ? UNDERLAP_HALF : OVERLAP_HALF;
			repeat (4) @(posedge ref_clk);
			#1 chk({24'h0, aperture_x}, {24'h0, x0 - half});
			chk({24'h0, aperture_y}, {24'h0, y0});
			chk({31'h0, tracking}, 1);
			wait_ev(1, n);
			chk(32'($signed(err_diff) >= -2 && $signed(err_diff) <= 2), 1);
			chk({31'h0, err_invalid}, 0);
			wait_ev(1, n);
			chk(n, 2 * DW);
		end
		// Slow scan dwells four times as long from the same timer.
		wr(REG_CTRL, 32'h8);
		wait_ev(1, n);
		wait_ev(1, n);
		chk(n, 2 * SLOW_FACTOR * DW);
		report_and_stop();
	end
endmodule
`default_nettype wire
